// [shared/audio_clock_pkg.sv]
`default_nettype none
package audio_clock_pkg;

	// Register addresses
	localparam logic [6:0] ADDR_CLOCK_SOURCE_SELECT = 7'h08;
	localparam logic [6:0] ADDR_PLAYBACK_CONTROL_ONE = 7'h0F;
	localparam logic [6:0] ADDR_CAPTURE_CONTROL_ONE = 7'h1D;
	localparam int REG_W = 9;

	// Field positions
	localparam int CONV_CLK_LSB = 0;
	localparam int CAP_CLK_LSB = 2;
	localparam int TX_CLK_LSB = 4;
	localparam int MANUAL_BIT = 6;
	localparam int RX2CONV_BIT = 8;
	localparam int CAP_RATIO_LSB = 5;

	// Values after reset
	localparam logic [1:0] CONV_CLK_RST = 2'h0;
	localparam logic [1:0] CAP_CLK_RST = 2'h0;
	localparam logic [1:0] TX_CLK_RST = 2'h1;
	localparam logic MANUAL_RST = 1'b0;
	localparam logic RX2CONV_RST = 1'b0;
	localparam logic [2:0] CAP_RATIO_RST = 3'h2;

	// Routing source codes
	localparam logic [1:0] SRC1_SPDIF_RX = 2'h0;
	localparam logic [1:0] SRC1_PRIMARY_RX = 2'h1;
	localparam logic [1:0] SRC1_SECONDARY_RX = 2'h2;
	localparam logic [1:0] TXSRC_SPDIF_RX = 2'h0;
	localparam logic [1:0] TXSRC_PRIMARY_RX = 2'h1;
	localparam logic [1:0] TXSRC_SECONDARY_RX = 2'h2;
	localparam logic [1:0] TXSRC_CAPTURE = 2'h3;

	// Core clock sources, value is also the pin index in the sampled vector
	typedef enum logic [1:0] {
		SRC_MASTER_PIN = 2'b00,
		SRC_CAPTURE_PIN = 2'b01,
		SRC_SYNTH1 = 2'b10,
		SRC_SYNTH2 = 2'b11
	} clk_src_e;

	// Rate references, frame clocks sit at pin index REF_PIN_BASE + code
	typedef enum logic [2:0] {
		REF_RECOVERED = 3'b000,
		REF_PRIMARY_RX = 3'b001,
		REF_SECONDARY_RX = 3'b010,
		REF_PRIMARY_TX = 3'b011,
		REF_SECONDARY_PORT = 3'b100,
		REF_FIELD = 3'b101
	} ref_sel_e;

	localparam int PIN_COUNT = 9;
	localparam int REF_PIN_BASE = 4;
	localparam int CNT_W = 11;
	localparam logic [CNT_W-1:0] CNT_MAX = 11'h7FF;

	function automatic clk_src_e conv_field_src(input logic [1:0] f);
		case (f)
			2'h1: conv_field_src = SRC_SYNTH1;
			2'h2: conv_field_src = SRC_SYNTH2;
			default: conv_field_src = SRC_MASTER_PIN;
		endcase
	endfunction

	function automatic clk_src_e other_field_src(input logic [1:0] f);
		case (f)
			2'h0: other_field_src = SRC_CAPTURE_PIN;
			2'h1: other_field_src = SRC_SYNTH1;
			2'h2: other_field_src = SRC_SYNTH2;
			default: other_field_src = SRC_MASTER_PIN;
		endcase
	endfunction

	function automatic logic [CNT_W-1:0] ratio_value(input logic [2:0] code);
		case (code)
			3'h0: ratio_value = 11'h080;
			3'h1: ratio_value = 11'h0C0;
			3'h2: ratio_value = 11'h100;
			3'h3: ratio_value = 11'h180;
			3'h4: ratio_value = 11'h200;
			3'h5: ratio_value = 11'h300;
			default: ratio_value = 11'h480;
		endcase
	endfunction

	// Snap a measured core-edges-per-frame count to the nearest ratio
	function automatic logic [2:0] ratio_code(input logic [CNT_W-1:0] cnt);
		if (cnt < 11'h0A0) ratio_code = 3'h0;
		else if (cnt < 11'h0E0) ratio_code = 3'h1;
		else if (cnt < 11'h140) ratio_code = 3'h2;
		else if (cnt < 11'h1C0) ratio_code = 3'h3;
		else if (cnt < 11'h280) ratio_code = 3'h4;
		else if (cnt < 11'h3C0) ratio_code = 3'h5;
		else ratio_code = 3'h6;
	endfunction

endpackage
`default_nettype wire

// [rtl/rate_divider.sv]
`timescale 1ns/100ps
`default_nettype none
module rate_divider (
	input wire logic clk,
	input wire logic rst,
	input wire logic coreRise,
	input wire logic refRise,
	input wire logic useField,
	input wire logic [2:0] fieldCode,
	output logic [2:0] ratioCode_r,
	output logic fsPulse_r
);

	logic [audio_clock_pkg::CNT_W-1:0] measCnt_r;
	logic [audio_clock_pkg::CNT_W-1:0] divCnt_r;
	logic [2:0] pendCode_r;
	logic boundary;

	assign boundary = coreRise &&
		(divCnt_r >= audio_clock_pkg::ratio_value(ratioCode_r) - 11'h001);

	// Core edges per reference frame
	always_ff @(posedge clk) begin
		if (rst) begin
			measCnt_r <= '0;
		end else if (refRise) begin
			measCnt_r <= {10'h000, coreRise};
		end else if (coreRise && measCnt_r != audio_clock_pkg::CNT_MAX) begin
			measCnt_r <= measCnt_r + 11'h001;
		end
	end

	// Measured ratio is latched only on a whole reference frame
	always_ff @(posedge clk) begin
		if (rst) begin
			pendCode_r <= audio_clock_pkg::CAP_RATIO_RST;
		end else if (useField) begin
			pendCode_r <= fieldCode;
		end else if (refRise) begin
			pendCode_r <= audio_clock_pkg::ratio_code(measCnt_r);
		end
	end

	// Divider, new ratio only taken at the wrap so no short period
	always_ff @(posedge clk) begin
		if (rst) begin
			divCnt_r <= '0;
			ratioCode_r <= audio_clock_pkg::CAP_RATIO_RST;
			fsPulse_r <= 1'b0;
		end else begin
			fsPulse_r <= boundary;
			if (boundary) begin
				divCnt_r <= '0;
				ratioCode_r <= pendCode_r;
			end else if (coreRise) begin
				divCnt_r <= divCnt_r + 11'h001;
			end
		end
	end

	chk_ratio_at_wrap: assert property (@(posedge clk) disable iff (rst)
		$changed(ratioCode_r) |-> fsPulse_r)
		else $error("ratio changed away from a frame wrap");

	chk_fs_isolated: assert property (@(posedge clk) disable iff (rst)
		fsPulse_r |=> !fsPulse_r [*2])
		else $error("fs pulses too close together");

endmodule // rate_divider
`default_nettype wire

// [rtl/audio_clock_rate_select.sv]
`timescale 1ns/100ps
`default_nettype none
module audio_clock_rate_select (
	input wire logic clk,
	input wire logic rst,
	input wire logic regWrEn,
	input wire logic [6:0] regAddr,
	input wire logic [8:0] regWrData,
	output logic [8:0] regRdData_r,
	input wire logic masterClockPin,
	input wire logic captureMasterClockPin,
	input wire logic firstSynthClock,
	input wire logic secondSynthClock,
	input wire logic recoveredFrameClock,
	input wire logic primaryRxFrameClock,
	input wire logic secondaryRxFrameClock,
	input wire logic primaryTxFrameClock,
	input wire logic secondaryPortFrameClock,
	input wire logic [1:0] converter1SourceSelect,
	input wire logic [1:0] spdifTxSource,
	input wire logic captureToPrimaryTx,
	input wire logic captureToSecondaryTx,
	input wire logic spdifRxEnable,
	output logic [1:0] convClkSel_r,
	output logic [1:0] capClkSel_r,
	output logic [1:0] txClkSel_r,
	output logic convCoreClk_r,
	output logic capCoreClk_r,
	output logic txCoreClk_r,
	output logic spdifRxCoreClk_r,
	output logic [2:0] convRatio,
	output logic [2:0] capRatio,
	output logic [2:0] txRatio,
	output logic convFsPulse,
	output logic capFsPulse,
	output logic txFsPulse,
	output logic conv234PowerDown_r,
	output logic conv234FromPrimary_r
);

	localparam int PC = audio_clock_pkg::PIN_COUNT;

	logic [1:0] convClockSourceField_r;
	logic [1:0] captureClockSourceField_r;
	logic [1:0] transmitClockSourceField_r;
	logic manualClockOverride_r;
	logic receiverToConverterRateMode_r;
	logic [2:0] captureRatioField_r;
	logic [PC-1:0] pinMeta_r;
	logic [PC-1:0] pinSync_r;
	logic [PC-1:0] pinPrev_r;
	logic [PC-1:0] pinRise;
	audio_clock_pkg::clk_src_e convWant;
	audio_clock_pkg::clk_src_e capWant;
	audio_clock_pkg::clk_src_e txWant;
	audio_clock_pkg::ref_sel_e convRef_r;
	audio_clock_pkg::ref_sel_e capRef_r;
	audio_clock_pkg::ref_sel_e txRef_r;
	audio_clock_pkg::ref_sel_e convRefNxt;
	audio_clock_pkg::ref_sel_e capRefNxt;
	audio_clock_pkg::ref_sel_e txRefNxt;

	function automatic logic ref_rise(input logic [PC-1:0] rise,
		input audio_clock_pkg::ref_sel_e r);
		if (r == audio_clock_pkg::REF_FIELD) begin
			ref_rise = 1'b0;
		end else begin
			ref_rise = rise[audio_clock_pkg::REF_PIN_BASE + int'(r)];
		end
	endfunction

	// Register writes
	always_ff @(posedge clk) begin
		if (rst) begin
			convClockSourceField_r <= audio_clock_pkg::CONV_CLK_RST;
			captureClockSourceField_r <= audio_clock_pkg::CAP_CLK_RST;
			transmitClockSourceField_r <= audio_clock_pkg::TX_CLK_RST;
			manualClockOverride_r <= audio_clock_pkg::MANUAL_RST;
		end else if (regWrEn && regAddr == audio_clock_pkg::ADDR_CLOCK_SOURCE_SELECT) begin
			convClockSourceField_r <= regWrData[audio_clock_pkg::CONV_CLK_LSB +: 2];
			captureClockSourceField_r <= regWrData[audio_clock_pkg::CAP_CLK_LSB +: 2];
			transmitClockSourceField_r <= regWrData[audio_clock_pkg::TX_CLK_LSB +: 2];
			manualClockOverride_r <= regWrData[audio_clock_pkg::MANUAL_BIT];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			receiverToConverterRateMode_r <= audio_clock_pkg::RX2CONV_RST;
		end else if (regWrEn && regAddr == audio_clock_pkg::ADDR_PLAYBACK_CONTROL_ONE) begin
			receiverToConverterRateMode_r <= regWrData[audio_clock_pkg::RX2CONV_BIT];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			captureRatioField_r <= audio_clock_pkg::CAP_RATIO_RST;
		end else if (regWrEn && regAddr == audio_clock_pkg::ADDR_CAPTURE_CONTROL_ONE) begin
			captureRatioField_r <= regWrData[audio_clock_pkg::CAP_RATIO_LSB +: 3];
		end
	end

	// Readback; bits owned by other blocks read as zero
	always_ff @(posedge clk) begin
		if (rst) begin
			regRdData_r <= '0;
		end else begin
			regRdData_r <= '0;
			case (regAddr)
				audio_clock_pkg::ADDR_CLOCK_SOURCE_SELECT: begin
					regRdData_r[audio_clock_pkg::CONV_CLK_LSB +: 2] <= convClockSourceField_r;
					regRdData_r[audio_clock_pkg::CAP_CLK_LSB +: 2] <= captureClockSourceField_r;
					regRdData_r[audio_clock_pkg::TX_CLK_LSB +: 2] <= transmitClockSourceField_r;
					regRdData_r[audio_clock_pkg::MANUAL_BIT] <= manualClockOverride_r;
				end
				audio_clock_pkg::ADDR_PLAYBACK_CONTROL_ONE: begin
					regRdData_r[audio_clock_pkg::RX2CONV_BIT] <= receiverToConverterRateMode_r;
				end
				audio_clock_pkg::ADDR_CAPTURE_CONTROL_ONE: begin
					regRdData_r[audio_clock_pkg::CAP_RATIO_LSB +: 3] <= captureRatioField_r;
				end
				default: begin
				end
			endcase
		end
	end

	// Clock pins are sampled, not used as clocks; they must run well below clk/2
	always_ff @(posedge clk) begin
		if (rst) begin
			pinMeta_r <= '0;
			pinSync_r <= '0;
			pinPrev_r <= '0;
		end else begin
			pinMeta_r <= {secondaryPortFrameClock, primaryTxFrameClock, secondaryRxFrameClock,
				primaryRxFrameClock, recoveredFrameClock, secondSynthClock, firstSynthClock,
				captureMasterClockPin, masterClockPin};
			pinSync_r <= pinMeta_r;
			pinPrev_r <= pinSync_r;
		end
	end

	assign pinRise = pinSync_r & ~pinPrev_r;

	// Automatic clock selection
	always_comb begin
		convWant = audio_clock_pkg::conv_field_src(convClockSourceField_r);
		capWant = audio_clock_pkg::other_field_src(captureClockSourceField_r);
		txWant = audio_clock_pkg::other_field_src(transmitClockSourceField_r);
		if (!manualClockOverride_r) begin
			if (spdifRxEnable) begin
				convWant = audio_clock_pkg::SRC_MASTER_PIN;
				if (capWant[1]) begin
					capWant = audio_clock_pkg::SRC_CAPTURE_PIN;
				end
				if (txWant[1]) begin
					txWant = audio_clock_pkg::SRC_CAPTURE_PIN;
				end
			end
			if (spdifTxSource == audio_clock_pkg::TXSRC_SPDIF_RX) begin
				txWant = audio_clock_pkg::SRC_SYNTH1;
			end
		end
	end

	// Rate references from routing
	always_comb begin
		case (converter1SourceSelect)
			audio_clock_pkg::SRC1_PRIMARY_RX: convRefNxt = audio_clock_pkg::REF_PRIMARY_RX;
			audio_clock_pkg::SRC1_SECONDARY_RX: convRefNxt = audio_clock_pkg::REF_SECONDARY_RX;
			audio_clock_pkg::SRC1_SPDIF_RX: convRefNxt = receiverToConverterRateMode_r ?
				audio_clock_pkg::REF_PRIMARY_RX : audio_clock_pkg::REF_RECOVERED;
			default: convRefNxt = audio_clock_pkg::REF_PRIMARY_RX;
		endcase
		if (captureToPrimaryTx) begin
			capRefNxt = audio_clock_pkg::REF_PRIMARY_TX;
		end else if (captureToSecondaryTx) begin
			capRefNxt = audio_clock_pkg::REF_SECONDARY_PORT;
		end else begin
			capRefNxt = audio_clock_pkg::REF_FIELD;
		end
		case (spdifTxSource)
			audio_clock_pkg::TXSRC_SPDIF_RX: txRefNxt = audio_clock_pkg::REF_RECOVERED;
			audio_clock_pkg::TXSRC_PRIMARY_RX: txRefNxt = audio_clock_pkg::REF_PRIMARY_RX;
			audio_clock_pkg::TXSRC_SECONDARY_RX: txRefNxt = audio_clock_pkg::REF_SECONDARY_RX;
			default: txRefNxt = captureToPrimaryTx ?
				audio_clock_pkg::REF_PRIMARY_TX : audio_clock_pkg::REF_FIELD;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			convRef_r <= audio_clock_pkg::REF_RECOVERED;
			capRef_r <= audio_clock_pkg::REF_FIELD;
			txRef_r <= audio_clock_pkg::REF_RECOVERED;
		end else begin
			convRef_r <= convRefNxt;
			capRef_r <= capRefNxt;
			txRef_r <= txRefNxt;
		end
	end

	// Power and data steering of converters 2-4
	always_ff @(posedge clk) begin
		if (rst) begin
			conv234PowerDown_r <= 1'b0;
			conv234FromPrimary_r <= 1'b0;
		end else begin
			conv234PowerDown_r <= converter1SourceSelect == audio_clock_pkg::SRC1_SPDIF_RX &&
				!receiverToConverterRateMode_r;
			conv234FromPrimary_r <= converter1SourceSelect == audio_clock_pkg::SRC1_SPDIF_RX &&
				receiverToConverterRateMode_r;
		end
	end

	// Mux selects switch only at the path's own frame wrap
	always_ff @(posedge clk) begin
		if (rst) begin
			convClkSel_r <= audio_clock_pkg::conv_field_src(audio_clock_pkg::CONV_CLK_RST);
			capClkSel_r <= audio_clock_pkg::other_field_src(audio_clock_pkg::CAP_CLK_RST);
			txClkSel_r <= audio_clock_pkg::other_field_src(audio_clock_pkg::TX_CLK_RST);
		end else begin
			if (convFsPulse) begin
				convClkSel_r <= convWant;
			end
			if (capFsPulse) begin
				capClkSel_r <= capWant;
			end
			if (txFsPulse) begin
				txClkSel_r <= txWant;
			end
		end
	end

	// Selected core clocks as sampled levels
	always_ff @(posedge clk) begin
		if (rst) begin
			convCoreClk_r <= 1'b0;
			capCoreClk_r <= 1'b0;
			txCoreClk_r <= 1'b0;
			spdifRxCoreClk_r <= 1'b0;
		end else begin
			convCoreClk_r <= pinSync_r[convClkSel_r];
			capCoreClk_r <= pinSync_r[capClkSel_r];
			txCoreClk_r <= pinSync_r[txClkSel_r];
			spdifRxCoreClk_r <= spdifRxEnable && pinSync_r[audio_clock_pkg::SRC_SYNTH1];
		end
	end

	rate_divider convRate (
		.clk(clk),
		.rst(rst),
		.coreRise(pinRise[convClkSel_r]),
		.refRise(ref_rise(pinRise, convRef_r)),
		.useField(1'b0),
		.fieldCode(captureRatioField_r),
		.ratioCode_r(convRatio),
		.fsPulse_r(convFsPulse)
	);

	rate_divider capRate (
		.clk(clk),
		.rst(rst),
		.coreRise(pinRise[capClkSel_r]),
		.refRise(ref_rise(pinRise, capRef_r)),
		.useField(capRef_r == audio_clock_pkg::REF_FIELD),
		.fieldCode(captureRatioField_r),
		.ratioCode_r(capRatio),
		.fsPulse_r(capFsPulse)
	);

	rate_divider txRate (
		.clk(clk),
		.rst(rst),
		.coreRise(pinRise[txClkSel_r]),
		.refRise(ref_rise(pinRise, txRef_r)),
		.useField(txRef_r == audio_clock_pkg::REF_FIELD),
		.fieldCode(captureRatioField_r),
		.ratioCode_r(txRatio),
		.fsPulse_r(txFsPulse)
	);

	sequence convWrapSeq;
		convFsPulse;
	endsequence

	sequence convTakeSeq(audio_clock_pkg::clk_src_e want);
		##1 convClkSel_r == $past(want);
	endsequence

	chk_conv_switch_wrap: assert property (@(posedge clk) disable iff (rst)
		convWrapSeq |-> convTakeSeq(convWant))
		else $error("converter select not taken at frame wrap");

	chk_conv_hold_between: assert property (@(posedge clk) disable iff (rst)
		!convFsPulse |=> $stable(convClkSel_r))
		else $error("converter select changed mid frame");

	chk_conv_no_synth: assert property (@(posedge clk) disable iff (rst)
		convFsPulse && !manualClockOverride_r && spdifRxEnable |=> !convClkSel_r[1])
		else $error("synthesiser offered to converters during receive");

	chk_cap_restricted: assert property (@(posedge clk) disable iff (rst)
		capFsPulse && !manualClockOverride_r && spdifRxEnable |=> !capClkSel_r[1])
		else $error("capture clock uses synthesiser during receive");

	chk_tx_auto_synth: assert property (@(posedge clk) disable iff (rst)
		txFsPulse && !manualClockOverride_r && spdifTxSource == audio_clock_pkg::TXSRC_SPDIF_RX
		|=> txClkSel_r == audio_clock_pkg::SRC_SYNTH1)
		else $error("transmit core clock not synth one for receive data");

	chk_manual_field: assert property (@(posedge clk) disable iff (rst)
		manualClockOverride_r && capFsPulse |=> capClkSel_r ==
		audio_clock_pkg::other_field_src($past(captureClockSourceField_r)))
		else $error("manual capture selection not honoured");

	chk_pwrdn_mode: assert property (@(posedge clk) disable iff (rst)
		converter1SourceSelect == audio_clock_pkg::SRC1_SPDIF_RX && !receiverToConverterRateMode_r
		|=> conv234PowerDown_r && convRef_r == audio_clock_pkg::REF_RECOVERED)
		else $error("recovered rate mode not applied");

	chk_rx2conv_mode: assert property (@(posedge clk) disable iff (rst)
		converter1SourceSelect == audio_clock_pkg::SRC1_SPDIF_RX && receiverToConverterRateMode_r
		|=> conv234FromPrimary_r && !conv234PowerDown_r
		&& convRef_r == audio_clock_pkg::REF_PRIMARY_RX)
		else $error("primary frame rate mode not applied");

	chk_conv_port_ref: assert property (@(posedge clk) disable iff (rst)
		converter1SourceSelect == audio_clock_pkg::SRC1_SECONDARY_RX
		|=> convRef_r == audio_clock_pkg::REF_SECONDARY_RX)
		else $error("secondary receive reference not used");

	chk_cap_ref_prio: assert property (@(posedge clk) disable iff (rst)
		captureToPrimaryTx |=> capRef_r == audio_clock_pkg::REF_PRIMARY_TX)
		else $error("primary transmit reference not used for capture");

endmodule // audio_clock_rate_select
`default_nettype wire

// [tb/test_audio_clock_rate_select.sv]
`timescale 1ns/100ps
`default_nettype none
module test_audio_clock_rate_select;
	typedef struct {int sel; logic [8:0] exp;} note_s;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic regWrEn = 1'b0;
	logic [6:0] regAddr = 7'h00;
	logic [8:0] regWrData = 9'h000;
	logic [8:0] regRdData_r;
	logic [3:0] pin = 4'h0;
	logic [4:0] frm = 5'h00;
	logic [1:0] conv1Src = 2'h1;
	logic [1:0] txSrc = 2'h3;
	logic capPrim = 1'b0;
	logic capSec = 1'b0;
	logic rxEn = 1'b0;
	logic [1:0] convSel, capSel, txSel;
	logic [2:0] convRatio, capRatio, txRatio, fsp;
	logic powerDown, fromPrimary;
	logic [3:0] core;
	logic [11:0] pinHist = 12'h000;
	logic [8:0] d;
	note_s notes[$];
	note_s n;
	int miscompares = 0;
	int check_count = 0;
	int cyc = 0;
	// Recovered, primary rx, secondary rx, primary tx, secondary port
	int frameLen[5] = '{1536, 1024, 768, 2048, 512};
	string names[10] = '{"readback", "convSel", "capSel", "txSel", "convRatio", "capRatio",
		"txRatio", "powerDown", "fromPrimary", "coreClocks"};
	logic [1:0] convMap[4] = '{2'h0, 2'h2, 2'h3, 2'h0};
	logic [1:0] otherMap[4] = '{2'h1, 2'h2, 2'h3, 2'h0};

	audio_clock_rate_select uut (.clk(clk), .rst(rst), .regWrEn(regWrEn), .regAddr(regAddr),
		.regWrData(regWrData), .regRdData_r(regRdData_r), .masterClockPin(pin[0]),
		.captureMasterClockPin(pin[1]), .firstSynthClock(pin[2]), .secondSynthClock(pin[3]),
		.recoveredFrameClock(frm[0]), .primaryRxFrameClock(frm[1]),
		.secondaryRxFrameClock(frm[2]), .primaryTxFrameClock(frm[3]),
		.secondaryPortFrameClock(frm[4]), .converter1SourceSelect(conv1Src),
		.spdifTxSource(txSrc), .captureToPrimaryTx(capPrim), .captureToSecondaryTx(capSec),
		.spdifRxEnable(rxEn), .convClkSel_r(convSel), .capClkSel_r(capSel),
		.txClkSel_r(txSel), .convCoreClk_r(core[0]), .capCoreClk_r(core[1]),
		.txCoreClk_r(core[2]), .spdifRxCoreClk_r(core[3]), .convRatio(convRatio),
		.capRatio(capRatio), .txRatio(txRatio),
		.convFsPulse(fsp[0]), .capFsPulse(fsp[1]), .txFsPulse(fsp[2]),
		.conv234PowerDown_r(powerDown), .conv234FromPrimary_r(fromPrimary));

	always #5 clk = ~clk;

	// Core pins 0-2 toggle every 2 cycles and pin 3 every 4, slow enough for the two-flop sampling
	always @(posedge clk) begin
		cyc <= cyc + 1;
		pin <= {cyc[2], cyc[1], ~cyc[1], cyc[1]};
		// Core outputs lag the pins by three samples
		pinHist <= {pinHist[7:0], pin};
		for (int i = 0; i < 5; i++) frm[i] <= (cyc % frameLen[i]) < frameLen[i] / 2;
		if (cyc == 99000) begin
			$display("Cycle limit reached");
			miscompares++;
			give_verdict();
		end
	end

	function automatic logic [8:0] obs(input int s);
		case (s)
			0: obs = regRdData_r;
			1: obs = 9'(convSel);
			2: obs = 9'(capSel);
			3: obs = 9'(txSel);
			4: obs = 9'(convRatio);
			5: obs = 9'(capRatio);
			6: obs = 9'(txRatio);
			7: obs = 9'(powerDown);
			8: obs = 9'(fromPrimary);
			default: obs = 9'(core ^ {rxEn & pinHist[10], pinHist[8 + txSel],
				pinHist[8 + capSel], pinHist[8 + convSel]});
		endcase
	endfunction

	always @(negedge clk) begin
		if (notes.size() > 0) begin
			n = notes.pop_front();
			check_count++;
			if (obs(n.sel) !== n.exp) begin
				miscompares++;
				$display("CHECK FAILED %s expected %h seen %h", names[n.sel], n.exp, obs(n.sel));
			end
		end
	end

	task automatic give_verdict;
		$display("Comparisons %0d, mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(input int s, input logic [8:0] e);
		notes.push_back('{s, e});
		@(negedge clk);
	endtask

	task automatic wr(input logic [6:0] a, input logic [8:0] v);
		@(posedge clk);
		regWrEn <= 1'b1;
		regAddr <= a;
		regWrData <= v;
		@(posedge clk);
		regWrEn <= 1'b0;
	endtask

	task automatic rd(input logic [6:0] a, input logic [8:0] e);
		@(posedge clk);
		regAddr <= a;
		repeat (2) @(posedge clk);
		chk(0, e);
	endtask

	task automatic wait_pulse(input int p);
		int k;
		k = 0;
		do begin
			@(negedge clk);
			k++;
		end while (fsp[p] !== 1'b1 && k < 8000);
		if (k >= 8000) begin
			miscompares++;
			$display("CHECK FAILED frame pulse expected 1 seen 0");
		end
	endtask

	task automatic route(input logic [1:0] c, t, input logic p, s, r);
		@(posedge clk);
		conv1Src <= c;
		txSrc <= t;
		capPrim <= p;
		capSec <= s;
		rxEn <= r;
	endtask

	// Two full reference frames must be measured before the next wrap applies them
	task automatic settle;
		repeat (3) @(posedge frm[3]);
		for (int p = 0; p < 3; p++) wait_pulse(p);
		repeat (2) @(posedge clk);
	endtask

	task automatic expect_all(input logic [1:0] a, b, c, input logic [2:0] x, y, z);
		chk(1, 9'(a));
		chk(2, 9'(b));
		chk(3, 9'(c));
		chk(4, 9'(x));
		chk(5, 9'(y));
		chk(6, 9'(z));
		chk(9, 9'h000);
	endtask

	initial begin
		void'($urandom(11210));
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		expect_all(2'h0, 2'h1, 2'h2, 3'h2, 3'h2, 3'h2);
		rd(7'h08, 9'h010);
		rd(7'h0F, 9'h000);
		rd(7'h1D, 9'h040);
		wr(7'h09, 9'($urandom));
		rd(7'h10, 9'h000);
		rd(7'h08, 9'h010);
		$display("Reset and register map test done");
		for (int c = 0; c < 7; c++) begin
			wr(7'h1D, (9'($urandom) & 9'h11F) | 9'(c << 5));
			repeat (3) @(posedge clk);
			wait_pulse(1);
			wait_pulse(2);
			chk(5, 9'(c));
			chk(6, 9'(c));
			rd(7'h1D, 9'(c << 5));
		end
		// Back to the default ratio so later waits stay short
		wr(7'h1D, 9'h040);
		$display("Capture ratio field test done");
		route(2'h1, 2'h2, 1'b1, 1'b0, 1'b0);
		settle();
		expect_all(2'h0, 2'h1, 2'h2, 3'h2, 3'h4, 3'h1);
		route(2'h2, 2'h3, 1'b1, 1'b0, 1'b0);
		settle();
		expect_all(2'h0, 2'h1, 2'h2, 3'h1, 3'h4, 3'h4);
		route(2'h2, 2'h1, 1'b0, 1'b1, 1'b0);
		settle();
		expect_all(2'h0, 2'h1, 2'h2, 3'h1, 3'h0, 3'h2);
		$display("Port reference test done");
		wr(7'h08, 9'h025);
		route(2'h0, 2'h0, 1'b0, 1'b0, 1'b1);
		settle();
		expect_all(2'h0, 2'h1, 2'h2, 3'h3, 3'h2, 3'h3);
		chk(7, 9'h001);
		chk(8, 9'h000);
		wr(7'h0F, 9'h100);
		settle();
		chk(4, 9'h002);
		chk(7, 9'h000);
		chk(8, 9'h001);
		rd(7'h0F, 9'h100);
		route(2'h1, 2'h0, 1'b0, 1'b0, 1'b1);
		repeat (3) @(posedge clk);
		chk(8, 9'h000);
		$display("Receiver routing test done");
		for (int f = 0; f < 4; f++) begin
			d = (9'($urandom) & 9'h180) | 9'h040 | 9'(f * 21);
			wr(7'h08, d);
			repeat (3) @(posedge clk);
			for (int p = 0; p < 3; p++) wait_pulse(p);
			repeat (2) @(posedge clk);
			chk(1, 9'(convMap[f]));
			chk(2, 9'(otherMap[f]));
			chk(3, 9'(otherMap[f]));
			rd(7'h08, d & 9'h07F);
		end
		$display("Manual override test done");
		give_verdict();
	end
endmodule // test_audio_clock_rate_select
`default_nettype wire
